// file: logic/swoc_pkg.sv
// Constants, register map and types of the switchgear object controller
package swoc_pkg;

    // Timing: one setting unit is one millisecond
    localparam int unsigned CLK_NS      = 8;
    localparam int unsigned TICK_NS     = 1_000_000;
    localparam int unsigned TICK_CYCLES = TICK_NS / CLK_NS;
    localparam int unsigned REC_DEPTH   = 12;
    localparam int unsigned REC_IW      = 4;
    localparam int unsigned TW          = 16;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CMD      = 8'h04;
    localparam logic [7:0] OFS_TRAVERSE = 8'h08;
    localparam logic [7:0] OFS_PLS_OPEN = 8'h0C;
    localparam logic [7:0] OFS_PLS_CLS  = 8'h10;
    localparam logic [7:0] OFS_TERM     = 8'h14;
    localparam logic [7:0] OFS_DI_SEL   = 8'h18;
    localparam logic [7:0] OFS_BLK_SEL  = 8'h1C;
    localparam logic [7:0] OFS_EVT_MASK = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
    localparam logic [7:0] OFS_STATUS   = 8'h2C;
    localparam logic [7:0] OFS_CNT_REQ  = 8'h30;
    localparam logic [7:0] OFS_CNT_FAIL = 8'h34;
    localparam logic [7:0] OFS_REC_SEL  = 8'h38;
    localparam logic [7:0] OFS_REC_DATA = 8'h3C;
    localparam logic [7:0] OFS_EVT_LAST = 8'h40;

    // CTRL fields
    localparam int unsigned CTRL_REMOTE    = 0;
    localparam int unsigned CTRL_USE_READY = 1;
    localparam int unsigned CTRL_USE_SYNC  = 2;
    localparam int unsigned CTRL_LATCH_LO  = 4;

    // CMD fields, write-one pulses
    localparam int unsigned CMD_OPEN      = 0;
    localparam int unsigned CMD_CLOSE     = 1;
    localparam int unsigned CMD_CLR_STATS = 2;
    localparam int unsigned CMD_CLR_RECS  = 3;
    localparam int unsigned CMD_CLR_LATCH = 4;
    localparam int unsigned CMD_CLR_FAIL  = 5;

    // DI_SEL: four 4-bit fields, index in [2:0], enable in [3]
    localparam int unsigned DSEL_LOC_OPEN  = 0;
    localparam int unsigned DSEL_LOC_CLOSE = 4;
    localparam int unsigned DSEL_REM_OPEN  = 8;
    localparam int unsigned DSEL_REM_CLOSE = 12;

    // Event bits
    localparam int unsigned EV_OPEN_REQ   = 0;
    localparam int unsigned EV_CLOSE_REQ  = 1;
    localparam int unsigned EV_OPEN_FAIL  = 2;
    localparam int unsigned EV_CLOSE_FAIL = 3;
    localparam int unsigned EV_INTER      = 4;
    localparam int unsigned EV_BAD        = 5;
    localparam int unsigned EV_REFUSED    = 6;
    localparam int unsigned EV_DONE       = 7;
    localparam int unsigned EV_W          = 8;

    // Reset values
    localparam logic [31:0]   CTRL_RST     = 32'h0000_0000;
    localparam logic [TW-1:0] TRAVERSE_RST = 16'h00C8;
    localparam logic [TW-1:0] PULSE_RST    = 16'h00C8;
    localparam logic [TW-1:0] TERM_RST     = 16'h2710;
    localparam logic [15:0]   DI_SEL_RST   = 16'h0000;
    localparam logic [EV_W-1:0] MASK_RST   = 8'h00;

    // Object position, coded as {closed contact, open contact}
    typedef enum logic [1:0] {
        ST_INTER  = 2'b00,
        ST_OPEN   = 2'b01,
        ST_CLOSED = 2'b10,
        ST_BAD    = 2'b11
    } swoc_pos_t;

    typedef enum logic [2:0] {
        FS_IDLE  = 3'b001,
        FS_PULSE = 3'b010,
        FS_WAIT  = 3'b100
    } swoc_fsm_t;

endpackage : swoc_pkg

// file: logic/swoc_timer.sv
// Millisecond countdown timer used for traverse, pulse and timeout
`timescale 1ns/100ps
`default_nettype none
module swoc_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // Control
    input  wire logic         load_in,
    input  wire logic         stop_in,
    input  wire logic         tick_in,
    input  wire logic [W-1:0] value_in,
    // State
    output logic              busy_out,
    output logic              expire_out
);

    logic [W-1:0] cnt_q;

    // Load beats stop; a zero setting expires one cycle after load
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q      <= '0;
            busy_out   <= 1'b0;
            expire_out <= 1'b0;
        end else begin
            expire_out <= 1'b0;
            if (load_in) begin
                cnt_q    <= value_in;
                busy_out <= 1'b1;
            end else if (stop_in) begin
                busy_out <= 1'b0;
            end else if (busy_out && cnt_q == '0) begin
                busy_out   <= 1'b0;
                expire_out <= 1'b1;
            end else if (busy_out && tick_in) begin
                cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule : swoc_timer
`default_nettype wire

// file: logic/swoc_top.sv
// Switchgear object controller: commands, supervision, records, registers
`timescale 1ns/100ps
`default_nettype none
module swoc_top
    import swoc_pkg::*;
#(
    parameter int unsigned TICK_CYC  = TICK_CYCLES,
    parameter int unsigned DI_W      = 8,
    parameter int unsigned BLK_W     = 16,
    parameter int unsigned REC_N     = REC_DEPTH
) (
    // Clock and reset
    input  wire logic             CLK_IN,
    input  wire logic             RST_IN,
    // Register port
    input  wire logic [7:0]       ADDR_IN,
    input  wire logic [31:0]      WDATA_IN,
    input  wire logic             WR_IN,
    input  wire logic             RD_IN,
    output logic      [31:0]      RDATA_OUT,
    // Object status and permissions
    input  wire logic             STAT_OPEN_IN,
    input  wire logic             STAT_CLOSED_IN,
    input  wire logic             READY_IN,
    input  wire logic             SYNC_IN,
    // Command sources and blocking
    input  wire logic             APP_OPEN_IN,
    input  wire logic             APP_CLOSE_IN,
    input  wire logic [DI_W-1:0]  DI_IN,
    input  wire logic [BLK_W-1:0] BLOCK_SRC_IN,
    // Object commands and indications
    output logic                  OPEN_CMD_OUT,
    output logic                  CLOSE_CMD_OUT,
    output logic      [3:0]       IND_OUT,
    output logic                  FAIL_OUT,
    output logic                  IRQ_OUT
);

    // Settings
    logic [31:0]      ctrl_q;
    logic [TW-1:0]    trav_q, pls_open_q, pls_cls_q, term_q;
    logic [15:0]      di_sel_q;
    logic [BLK_W-1:0] blk_sel_q;
    logic [EV_W-1:0]  evt_mask_q, irq_stat_q, irq_mask_q;
    logic [REC_IW-1:0] rec_sel_q;

    logic wr_ctrl, wr_cmd;
    assign wr_cmd  = WR_IN && ADDR_IN == OFS_CMD;
    assign wr_ctrl = WR_IN && ADDR_IN == OFS_CTRL;

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ctrl_q     <= CTRL_RST;
            trav_q     <= TRAVERSE_RST;
            pls_open_q <= PULSE_RST;
            pls_cls_q  <= PULSE_RST;
            term_q     <= TERM_RST;
            di_sel_q   <= DI_SEL_RST;
            blk_sel_q  <= '0;
            evt_mask_q <= MASK_RST;
            irq_mask_q <= '0;
            rec_sel_q  <= '0;
        end else if (WR_IN) begin
            unique case (ADDR_IN)
                OFS_CTRL:     ctrl_q     <= WDATA_IN;
                OFS_TRAVERSE: trav_q     <= WDATA_IN[TW-1:0];
                OFS_PLS_OPEN: pls_open_q <= WDATA_IN[TW-1:0];
                OFS_PLS_CLS:  pls_cls_q  <= WDATA_IN[TW-1:0];
                OFS_TERM:     term_q     <= WDATA_IN[TW-1:0];
                OFS_DI_SEL:   di_sel_q   <= WDATA_IN[15:0];
                OFS_BLK_SEL:  blk_sel_q  <= WDATA_IN[BLK_W-1:0];
                OFS_EVT_MASK: evt_mask_q <= WDATA_IN[EV_W-1:0];
                OFS_IRQ_MASK: irq_mask_q <= WDATA_IN[EV_W-1:0];
                OFS_REC_SEL:  rec_sel_q  <= WDATA_IN[REC_IW-1:0];
                default: ;
            endcase
        end
    end

    logic remote, use_ready, use_sync;
    assign remote    = ctrl_q[CTRL_REMOTE];
    assign use_ready = ctrl_q[CTRL_USE_READY];
    assign use_sync  = ctrl_q[CTRL_USE_SYNC];

    // Millisecond tick
    logic [31:0] tick_cnt_q;
    logic        tick_q;
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            tick_q     <= 1'b0;
        end
    end

    swoc_pos_t raw_pos, raw_prev_q, rep_q;
    assign raw_pos = swoc_pos_t'({STAT_CLOSED_IN, STAT_OPEN_IN});

    logic trav_exp;
    swoc_timer #(.W(TW)) u_trav (
        .clk_in     (CLK_IN),
        .rst_in     (RST_IN),
        .load_in    (raw_pos == ST_INTER && raw_prev_q != ST_INTER),
        .stop_in    (raw_pos != ST_INTER),
        .tick_in    (tick_q),
        .value_in   (trav_q),
        .busy_out   (),
        .expire_out (trav_exp)
    );

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            raw_prev_q <= ST_INTER;
            rep_q      <= ST_INTER;
        end else begin
            raw_prev_q <= raw_pos;
            if (raw_pos != ST_INTER || trav_exp)
                rep_q <= raw_pos;
        end
    end

    function automatic logic di_pick(input logic [3:0] f,
                                     input logic [DI_W-1:0] di);
        logic r;
        r = 1'b0;
        for (int i = 0; i < DI_W; i++) begin
            if (f[2:0] == 3'(i))
                r = di[i];
        end
        return r & f[3];
    endfunction : di_pick

    logic lo_open, lo_close, ro_open, ro_close;
    assign lo_open  = di_pick(di_sel_q[DSEL_LOC_OPEN +: 4], DI_IN);
    assign lo_close = di_pick(di_sel_q[DSEL_LOC_CLOSE +: 4], DI_IN);
    assign ro_open  = di_pick(di_sel_q[DSEL_REM_OPEN +: 4], DI_IN);
    assign ro_close = di_pick(di_sel_q[DSEL_REM_CLOSE +: 4], DI_IN);

    // source gating; application path bypasses it
    logic open_src, close_src, open_src_q, close_src_q;
    assign open_src  = APP_OPEN_IN | (remote ? ro_open : lo_open);
    assign close_src = APP_CLOSE_IN | (remote ? ro_close : lo_close);

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            open_src_q  <= 1'b0;
            close_src_q <= 1'b0;
        end else begin
            open_src_q  <= open_src;
            close_src_q <= close_src;
        end
    end

    // Levels act on their rising edge, bus commands are pulses
    logic open_req, close_req;
    assign open_req  = (open_src & ~open_src_q)
                     | (remote & wr_cmd & WDATA_IN[CMD_OPEN]);
    assign close_req = (close_src & ~close_src_q)
                     | (remote & wr_cmd & WDATA_IN[CMD_CLOSE]);

    logic blocked;
    assign blocked = |(BLOCK_SRC_IN & blk_sel_q);

    logic close_ok;
    assign close_ok = (~use_ready | READY_IN) & (~use_sync | SYNC_IN);

    // Open wins a tie, the safer direction
    swoc_fsm_t st_q, st_d;
    logic      idle, acc_open, acc_close, refused;
    assign idle      = st_q == FS_IDLE;
    assign acc_open  = idle & ~blocked & open_req;
    assign acc_close = idle & ~blocked & ~open_req & close_req & close_ok;
    assign refused   = (open_req | close_req) & ~acc_open & ~acc_close;

    logic      cmd_close_q, reached, pls_exp, term_exp, fail_ev, done_ev;
    swoc_pos_t target;
    assign target  = cmd_close_q ? ST_CLOSED : ST_OPEN;
    assign reached = !idle && raw_pos == target;

    always_comb begin
        st_d    = st_q;
        fail_ev = 1'b0;
        done_ev = 1'b0;
        unique case (st_q)
            FS_IDLE: begin
                if (acc_open || acc_close)
                    st_d = FS_PULSE;
            end
            FS_PULSE, FS_WAIT: begin
                if (reached) begin
                    st_d    = FS_IDLE;
                    done_ev = 1'b1;
                end else if (term_exp) begin
                    st_d    = FS_IDLE;
                    fail_ev = 1'b1;
                end else if (st_q == FS_PULSE && pls_exp) begin
                    st_d = FS_WAIT;
                end
            end
            default: st_d = FS_IDLE;
        endcase
    end

    swoc_timer #(.W(TW)) u_pulse (
        .clk_in     (CLK_IN),
        .rst_in     (RST_IN),
        .load_in    (acc_open | acc_close),
        .stop_in    (st_d != FS_PULSE),
        .tick_in    (tick_q),
        .value_in   (acc_close ? pls_cls_q : pls_open_q),
        .busy_out   (),
        .expire_out (pls_exp)
    );

    swoc_timer #(.W(TW)) u_term (
        .clk_in     (CLK_IN),
        .rst_in     (RST_IN),
        .load_in    (acc_open | acc_close),
        .stop_in    (st_d == FS_IDLE),
        .tick_in    (tick_q),
        .value_in   (term_q),
        .busy_out   (),
        .expire_out (term_exp)
    );

    logic clr_fail;
    assign clr_fail = wr_cmd & WDATA_IN[CMD_CLR_FAIL];

    // command outputs follow next state, so a reach cuts them at once
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            st_q          <= FS_IDLE;
            cmd_close_q   <= 1'b0;
            OPEN_CMD_OUT  <= 1'b0;
            CLOSE_CMD_OUT <= 1'b0;
            FAIL_OUT      <= 1'b0;
        end else begin
            st_q <= st_d;
            if (acc_open || acc_close)
                cmd_close_q <= acc_close;
            OPEN_CMD_OUT  <= st_d == FS_PULSE
                           && !(idle ? acc_close : cmd_close_q);
            CLOSE_CMD_OUT <= st_d == FS_PULSE
                           && (idle ? acc_close : cmd_close_q);
            if (fail_ev)
                FAIL_OUT <= 1'b1;
            else if (clr_fail || acc_open || acc_close)
                FAIL_OUT <= 1'b0;
        end
    end

    logic [15:0] n_open_q, n_close_q, n_ofail_q, n_cfail_q;
    logic        clr_stats;
    assign clr_stats = wr_cmd & WDATA_IN[CMD_CLR_STATS];
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            n_open_q  <= '0;
            n_close_q <= '0;
            n_ofail_q <= '0;
            n_cfail_q <= '0;
        end else if (clr_stats) begin
            n_open_q  <= '0;
            n_close_q <= '0;
            n_ofail_q <= '0;
            n_cfail_q <= '0;
        end else begin
            if (acc_open)
                n_open_q <= n_open_q + 16'h0001;
            if (acc_close)
                n_close_q <= n_close_q + 16'h0001;
            if (fail_ev && !cmd_close_q)
                n_ofail_q <= n_ofail_q + 16'h0001;
            if (fail_ev && cmd_close_q)
                n_cfail_q <= n_cfail_q + 16'h0001;
        end
    end

    // operation records: {close, failed, duration ms}
    logic [17:0]       rec_mem [REC_N];
    logic [REC_IW-1:0] rec_ptr_q;
    logic [TW-1:0]     op_time_q;
    logic              clr_recs;
    assign clr_recs = wr_cmd & WDATA_IN[CMD_CLR_RECS];

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            op_time_q <= '0;
        end else if (acc_open || acc_close) begin
            op_time_q <= '0;
        end else if (tick_q && op_time_q != '1) begin
            op_time_q <= op_time_q + 16'h0001;
        end
    end

    // Clear wins here: a record finishing with the clear is dropped
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rec_ptr_q <= '0;
            for (int i = 0; i < REC_N; i++)
                rec_mem[i] <= '0;
        end else if (clr_recs) begin
            rec_ptr_q <= '0;
            for (int i = 0; i < REC_N; i++)
                rec_mem[i] <= '0;
        end else if (fail_ev || done_ev) begin
            rec_mem[rec_ptr_q] <= {cmd_close_q, fail_ev, op_time_q};
            rec_ptr_q <= (rec_ptr_q == REC_IW'(REC_N - 1))
                       ? '0 : rec_ptr_q + 4'h1;
        end
    end

    // Events
    logic [EV_W-1:0] ev_raw, ev_rec;
    always_comb begin
        ev_raw                = '0;
        ev_raw[EV_OPEN_REQ]   = acc_open;
        ev_raw[EV_CLOSE_REQ]  = acc_close;
        ev_raw[EV_OPEN_FAIL]  = fail_ev & ~cmd_close_q;
        ev_raw[EV_CLOSE_FAIL] = fail_ev & cmd_close_q;
        ev_raw[EV_INTER]      = rep_q != ST_INTER && trav_exp;
        ev_raw[EV_BAD]        = raw_pos == ST_BAD && raw_prev_q != ST_BAD;
        ev_raw[EV_REFUSED]    = refused;
        ev_raw[EV_DONE]       = done_ev;
    end
    assign ev_rec = ev_raw & evt_mask_q;

    logic [EV_W-1:0] evt_last_q;
    logic [15:0]     evt_cnt_q;
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            evt_last_q <= '0;
            evt_cnt_q  <= '0;
            irq_stat_q <= '0;
            IRQ_OUT    <= 1'b0;
        end else begin
            if (|ev_rec) begin
                evt_last_q <= ev_rec;
                evt_cnt_q  <= evt_cnt_q + 16'h0001;
            end
            // Write-one clears, a new event in that cycle survives
            if (WR_IN && ADDR_IN == OFS_IRQ_STAT)
                irq_stat_q <= (irq_stat_q & ~WDATA_IN[EV_W-1:0]) | ev_rec;
            else
                irq_stat_q <= irq_stat_q | ev_rec;
            IRQ_OUT <= |(irq_stat_q & irq_mask_q);
        end
    end

    // status routes, latch held until source gone and cleared
    logic [3:0] ind_act;
    logic       clr_latch;
    assign ind_act   = {rep_q == ST_BAD, rep_q == ST_INTER,
                        rep_q == ST_CLOSED, rep_q == ST_OPEN};
    assign clr_latch = wr_cmd & WDATA_IN[CMD_CLR_LATCH];
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN)
            IND_OUT <= '0;
        else
            IND_OUT <= ind_act | (ctrl_q[CTRL_LATCH_LO +: 4] & IND_OUT
                                  & {4{~clr_latch}});
    end

    // Read mux; data stand only in the cycle after the strobe
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (ADDR_IN)
            OFS_CTRL:     rd_mux = ctrl_q;
            OFS_TRAVERSE: rd_mux = {16'h0000, trav_q};
            OFS_PLS_OPEN: rd_mux = {16'h0000, pls_open_q};
            OFS_PLS_CLS:  rd_mux = {16'h0000, pls_cls_q};
            OFS_TERM:     rd_mux = {16'h0000, term_q};
            OFS_DI_SEL:   rd_mux = {16'h0000, di_sel_q};
            OFS_BLK_SEL:  rd_mux = 32'(blk_sel_q);
            OFS_EVT_MASK: rd_mux = {24'h000000, evt_mask_q};
            OFS_IRQ_STAT: rd_mux = {24'h000000, irq_stat_q};
            OFS_IRQ_MASK: rd_mux = {24'h000000, irq_mask_q};
            OFS_STATUS:   rd_mux = {22'h000000, READY_IN, SYNC_IN,
                                    blocked, FAIL_OUT, cmd_close_q,
                                    st_q, rep_q};
            OFS_CNT_REQ:  rd_mux = {n_close_q, n_open_q};
            OFS_CNT_FAIL: rd_mux = {n_cfail_q, n_ofail_q};
            OFS_REC_SEL:  rd_mux = {28'h0000000, rec_sel_q};
            OFS_REC_DATA: rd_mux = (32'(rec_sel_q) < REC_N)
                                 ? {14'h0000, rec_mem[rec_sel_q]} : '0;
            OFS_EVT_LAST: rd_mux = {evt_cnt_q, 8'h00, evt_last_q};
            default:      rd_mux = '0;
        endcase
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN)
            RDATA_OUT <= '0;
        else
            RDATA_OUT <= RD_IN ? rd_mux : '0;
    end

endmodule : swoc_top
`default_nettype wire

// file: sim/swoc_breaker.sv
// Behavioural circuit breaker driving the two status contacts
`timescale 1ns/100ps
`default_nettype none
module swoc_breaker (
    // Clock, commands, behaviour: 0 prompt 1 slow 2 stuck 3 bad
    input  wire logic       clk_in,
    input  wire logic       open_in,
    input  wire logic       close_in,
    input  wire logic [1:0] mode_in,
    // Contacts
    output logic            stat_open_out,
    output logic            stat_closed_out
);
    logic [1:0] pos_q = 2'b01;
    logic       tgt_q = 1'b0;
    int         cnt_q = 0;
    assign {stat_closed_out, stat_open_out} = pos_q;
    // Leaves one end at once, lands on the other after the travel
    always @(posedge clk_in) begin
        if (mode_in == 2'd3) begin
            pos_q <= 2'b11;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
            if (cnt_q == 1) pos_q <= {tgt_q, !tgt_q};
        end else if (mode_in != 2'd2 && (open_in && pos_q != 2'b01
                     || close_in && pos_q != 2'b10)) begin
            tgt_q <= close_in;
            pos_q <= 2'b00;
            cnt_q <= (mode_in == 2'd1) ? 700 : 5;
        end
    end
endmodule : swoc_breaker
`default_nettype wire

// file: sim/swoc_properties.sv
// Port assertions for the switchgear object controller
`timescale 1ns/100ps
`default_nettype none
module swoc_properties #(
    parameter int unsigned TICK_CYC = 2
) (
    // Watched ports
    input wire logic        CLK_IN,
    input wire logic        RST_IN,
    input wire logic        STAT_OPEN_IN,
    input wire logic        STAT_CLOSED_IN,
    input wire logic        READY_IN,
    input wire logic        SYNC_IN,
    input wire logic [15:0] BLOCK_SRC_IN,
    input wire logic        OPEN_CMD_OUT,
    input wire logic        CLOSE_CMD_OUT,
    input wire logic [3:0]  IND_OUT,
    input wire logic        FAIL_OUT
);
    // Reset pulse setting plus one tick of timer slack
    localparam int MAXP = 201 * TICK_CYC + 4;
    int len_q;
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) len_q <= 0;
        else len_q <= (OPEN_CMD_OUT | CLOSE_CMD_OUT) ? len_q + 1 : 0;
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    chk_one_cmd: assert property (!(OPEN_CMD_OUT && CLOSE_CMD_OUT))
        else $error("both command outputs high");
    chk_open_cut: assert property (OPEN_CMD_OUT && STAT_OPEN_IN
        && !STAT_CLOSED_IN |=> !OPEN_CMD_OUT) else $error("open not cut");
    chk_close_cut: assert property (CLOSE_CMD_OUT && STAT_CLOSED_IN
        && !STAT_OPEN_IN |=> !CLOSE_CMD_OUT) else $error("close not cut");
    chk_pulse_max: assert property (len_q <= MAXP)
        else $error("command pulse too long");
    chk_bad_ind: assert property (STAT_OPEN_IN && STAT_CLOSED_IN
        |-> ##[1:2] IND_OUT[3]) else $error("bad not shown");
    chk_inter_wait: assert property ($fell(STAT_OPEN_IN | STAT_CLOSED_IN)
        |=> !IND_OUT[2] [*8]) else $error("intermediate too early");
    chk_open_route: assert property ((STAT_OPEN_IN && !STAT_CLOSED_IN)
        [*2] |-> ##[0:2] IND_OUT[0]) else $error("open not routed");
    chk_fail_stop: assert property ($rose(FAIL_OUT)
        |-> ##[0:1] !(OPEN_CMD_OUT || CLOSE_CMD_OUT)) else $error("no abort");
    chk_block_cmd: assert property ($rose(OPEN_CMD_OUT | CLOSE_CMD_OUT)
        |-> $past(BLOCK_SRC_IN) == 16'h0000) else $error("blocked command");
    chk_close_perm: assert property ($rose(CLOSE_CMD_OUT)
        |-> $past(READY_IN && SYNC_IN)) else $error("close without permit");
    cover property ($fell(OPEN_CMD_OUT));
    cover property ($rose(FAIL_OUT));
    cover property ($rose(IND_OUT[2]));
endmodule : swoc_properties
bind swoc_top swoc_properties #(.TICK_CYC(TICK_CYC)) u_props (
    .CLK_IN(CLK_IN), .RST_IN(RST_IN), .STAT_OPEN_IN(STAT_OPEN_IN),
    .STAT_CLOSED_IN(STAT_CLOSED_IN), .READY_IN(READY_IN), .SYNC_IN(SYNC_IN),
    .BLOCK_SRC_IN(BLOCK_SRC_IN), .OPEN_CMD_OUT(OPEN_CMD_OUT),
    .CLOSE_CMD_OUT(CLOSE_CMD_OUT), .IND_OUT(IND_OUT), .FAIL_OUT(FAIL_OUT));
`default_nettype wire

// file: sim/swoc_top_test.sv
// Self-checking bench of the switchgear object controller
`timescale 1ns/100ps
`default_nettype none
module swoc_top_test import swoc_pkg::*;;
    logic clk, rst, wr, rd, rdy, syn, so, sc, oc, cc, fail, irq;
    logic [7:0]  addr, di;
    logic [31:0] wdata, rdata, v, acc;
    logic [1:0]  app, mode;
    logic [15:0] blk;
    logic [3:0]  ind;
    int errors, n_checks;
    logic [7:0]  ra[6] = '{OFS_CTRL, OFS_TRAVERSE, OFS_PLS_OPEN, OFS_TERM,
                           OFS_EVT_MASK, 8'h44};
    logic [31:0] rv[6] = '{32'h0, 32'hC8, 32'hC8, 32'h2710, 32'h0, 32'h0};
    swoc_top #(.TICK_CYC(2)) uut (
        .CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .STAT_OPEN_IN(so),
        .STAT_CLOSED_IN(sc), .READY_IN(rdy), .SYNC_IN(syn),
        .APP_OPEN_IN(app[0]), .APP_CLOSE_IN(app[1]), .DI_IN(di),
        .BLOCK_SRC_IN(blk), .OPEN_CMD_OUT(oc), .CLOSE_CMD_OUT(cc),
        .IND_OUT(ind), .FAIL_OUT(fail), .IRQ_OUT(irq));
    swoc_breaker brk (.clk_in(clk), .open_in(oc), .close_in(cc),
        .mode_in(mode), .stat_open_out(so), .stat_closed_out(sc));
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk) v = rdata;
    endtask : rd_reg
    task automatic hit(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        app <= a;
        di  <= d;
        @(posedge clk);
        app <= 2'b00;
        di  <= 8'h00;
    endtask : hit
    // Poll status until the sequencer is back to idle, bounded
    task automatic to_idle();
        for (int i = 0; i < 400; i++) begin
            rd_reg(OFS_STATUS);
            if (v[4:2] == 3'b001) break;
        end
    endtask : to_idle
    task automatic recs();
        acc = 32'h0;
        for (int i = 0; i < 13; i++) begin
            wr_reg(OFS_REC_SEL, i);
            rd_reg(OFS_REC_DATA);
            acc = acc | v;
        end
    endtask : recs
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Whole sequence needs well under 30000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        test_done();
    end
    initial begin
        {wr, rd, app, di, blk, mode, addr, wdata} = '0;
        {rst, rdy, syn} = 3'b111;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (ra[i]) begin
            rd_reg(ra[i]);
            chk("reset value", v, rv[i]);
        end
        wr_reg(OFS_EVT_MASK, 32'hFF);
        wr_reg(OFS_IRQ_MASK, 32'h80);
        hit(2'b10, 8'h00);
        to_idle();
        chk("app close in local", v[1:0], 2'b10);
        chk("irq raised", irq, 1'b1);
        wr_reg(OFS_IRQ_STAT, 32'hFF);
        wr_reg(OFS_CMD, 32'h1);
        to_idle();
        chk("bus open in local", v[1:0], 2'b10);
        chk("irq cleared", irq, 1'b0);
        wr_reg(OFS_IRQ_MASK, 32'h00);
        wr_reg(OFS_CTRL, 32'h1);
        wr_reg(OFS_CMD, 32'h1);
        to_idle();
        chk("bus open in remote", v[1:0], 2'b01);
        chk("irq masked", irq, 1'b0);
        wr_reg(OFS_DI_SEL, 32'hA009);
        hit(2'b00, 8'h04);
        to_idle();
        chk("remote input close", v[1:0], 2'b10);
        hit(2'b00, 8'h02);
        to_idle();
        chk("local input in remote", v[1:0], 2'b10);
        hit(2'b01, 8'h00);
        to_idle();
        chk("app open in remote", v[1:0], 2'b01);
        rd_reg(OFS_CNT_REQ);
        chk("request counts", v, 32'h0002_0002);
        wr_reg(OFS_CTRL, 32'h17);
        rdy <= 1'b0;
        hit(2'b10, 8'h00);
        to_idle();
        chk("close not ready", v[1:0], 2'b01);
        @(posedge clk) rdy <= 1'b1;
        wr_reg(OFS_BLK_SEL, 32'hFFFF);
        blk <= 16'h0001;
        hit(2'b10, 8'h00);
        to_idle();
        chk("close blocked", v[1:0], 2'b01);
        @(posedge clk) blk <= 16'h0000;
        hit(2'b10, 8'h00);
        hit(2'b01, 8'h00);
        to_idle();
        chk("open while busy", v[1:0], 2'b10);
        wr_reg(OFS_CMD, 32'h4);
        mode <= 2'd1;
        hit(2'b01, 8'h00);
        repeat (500) @(negedge clk);
        chk("intermediate", ind[2], 1'b1);
        chk("pulse bounded", oc, 1'b0);
        to_idle();
        chk("slow open", v[1:0], 2'b01);
        mode <= 2'd2;
        wr_reg(OFS_TERM, 32'h14);
        hit(2'b10, 8'h00);
        to_idle();
        chk("fail raised", fail, 1'b1);
        rd_reg(OFS_CNT_FAIL);
        chk("fail counts", v, 32'h0001_0000);
        rd_reg(OFS_CNT_REQ);
        chk("counts after clear", v, 32'h0001_0001);
        recs();
        chk("failed close record", acc[17:16], 2'b11);
        wr_reg(OFS_CMD, 32'h28);
        mode <= 2'd3;
        recs();
        chk("records cleared", acc, 32'h0);
        chk("fail cleared", fail, 1'b0);
        to_idle();
        chk("bad status", v[1:0], 2'b11);
        chk("bad route", ind[3], 1'b1);
        chk("latched open", ind[0], 1'b1);
        test_done();
    end
endmodule : swoc_top_test
`default_nettype wire
